// ==== pkg/dual_port_i2c_defs.svh ====
`ifndef DUAL_PORT_I2C_DEFS_SVH
`define DUAL_PORT_I2C_DEFS_SVH

// fixed upper bits of the unique target address, bits 7..4 of the address byte
`define DPI_ADDR_UPPER      4'h4
// bits in one byte, and bit count at which the byte is complete
`define DPI_BYTE_BITS       4'h8
// byte sent once the announced count is exhausted
`define DPI_FILL_BYTE       8'hff
// event lines per port
`define DPI_EVENT_W         8
// reset values
`define DPI_RST_BYTE        8'h00
`define DPI_RST_ADDR        7'h00
`define DPI_RST_CNT         4'h0

`endif

// ==== pkg/dual_port_i2c_pkg.sv ====
package dual_port_i2c_pkg;

   typedef enum logic [8:0] {
      PS_IDLE   = 9'h001,
      PS_ADDR   = 9'h002,
      PS_ACK    = 9'h004,
      PS_RX     = 9'h008,
      PS_RXHOLD = 9'h010,
      PS_LOAD   = 9'h020,
      PS_TX     = 9'h040,
      PS_MACK   = 9'h080,
      PS_DONE   = 9'h100
   } port_state_t;

   typedef struct packed {
      port_state_t state;
      logic [1:0]  sclSync;
      logic [1:0]  sdaSync;
      logic        sclPrev;
      logic        sdaPrev;
      logic [3:0]  bitCnt;
      logic [7:0]  shift;
      logic        readDir;
      logic        masterAck;
      logic        sdaPull;
      logic        firstByte;
      logic        rxValid;
      logic [7:0]  rxData;
      logic        rxIsReg;
      logic [7:0]  regNum;
      logic        countPhase;
      logic [7:0]  remain;
      logic [6:0]  ownAddr;
      logic        addrLive;
      logic        bootPrev;
      logic        irqN;
   } port_regs_t;

endpackage

// ==== verilog/dual_port_i2c_target.sv ====
`include "dual_port_i2c_defs.svh"

// one serial target port: start/stop, address, byte moves, stretching, irq
module i2c_target_port (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rstn,
   // bus pins
   input  wire logic                         sclIn,
   output logic                              sclOut,
   output logic                              sclOe,
   input  wire logic                         sdaIn,
   output logic                              sdaOut,
   output logic                              sdaOe,
   output logic                              irqN,
   // boot and address
   input  wire logic                         bootDone,
   input  wire logic [2:0]                   strapCode,
   // events
   input  wire logic [`DPI_EVENT_W-1:0]      eventPending,
   input  wire logic [`DPI_EVENT_W-1:0]      eventMask,
   // received bytes
   output logic                              rxValid,
   input  wire logic                         rxReady,
   output logic [7:0]                        rxData,
   output logic                              rxIsReg,
   output logic [7:0]                        regNum,
   // bytes to send
   output logic                              txReq,
   output logic                              txCount,
   input  wire logic                         txValid,
   input  wire logic [7:0]                   txData,
   // status
   output logic                              busy
);

   dual_port_i2c_pkg::port_regs_t q;
   dual_port_i2c_pkg::port_regs_t n;

   logic sclS;
   logic sdaS;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic needCore;

   assign sclS      = q.sclSync[1];
   assign sdaS      = q.sdaSync[1];
   assign sclRise   = sclS & ~q.sclPrev;
   assign sclFall   = ~sclS & q.sclPrev;
   assign startSeen = sclS & q.sclPrev & q.sdaPrev & ~sdaS; // [R6]
   assign stopSeen  = sclS & q.sclPrev & ~q.sdaPrev & sdaS; // [R10]
   assign needCore  = q.countPhase | (q.remain != `DPI_RST_BYTE);

   always_comb begin
      n = q;
      n.sclSync = {q.sclSync[0], sclIn};
      n.sdaSync = {q.sdaSync[0], sdaIn};
      n.sclPrev = sclS;
      n.sdaPrev = sdaS;
      n.bootPrev = bootDone;
      // address fixed by boot before the port answers
      if (bootDone && !q.bootPrev) begin
         n.ownAddr  = {`DPI_ADDR_UPPER, strapCode}; // [R21] [R23]
         n.addrLive = 1'b1; // [R20]
      end
      n.irqN = ~|(eventPending & eventMask); // [R3] [R25]
      if (q.rxValid && rxReady) begin
         n.rxValid = 1'b0;
      end
      if (startSeen) begin
         // start or repeated start from any state
         n.state   = dual_port_i2c_pkg::PS_ADDR; // [R6]
         n.bitCnt  = `DPI_RST_CNT;
         n.sdaPull = 1'b0;
      end else if (stopSeen) begin
         n.state   = dual_port_i2c_pkg::PS_IDLE; // [R10]
         n.sdaPull = 1'b0;
      end else begin
         unique case (q.state)
            dual_port_i2c_pkg::PS_IDLE: begin
               n.sdaPull = 1'b0;
            end
            dual_port_i2c_pkg::PS_ADDR: begin
               if (sclRise) begin
                  // msb first, direction bit last
                  n.shift  = {q.shift[6:0], sdaS}; // [R9]
                  n.bitCnt = q.bitCnt + 4'h1;
               end else if (sclFall && q.bitCnt == `DPI_BYTE_BITS) begin
                  if (q.addrLive && q.shift[7:1] == q.ownAddr) begin
                     n.sdaPull    = 1'b1; // [R8]
                     n.readDir    = q.shift[0];
                     n.countPhase = q.shift[0];
                     n.firstByte  = ~q.shift[0];
                     n.state      = dual_port_i2c_pkg::PS_ACK;
                  end else begin
                     n.state = dual_port_i2c_pkg::PS_IDLE;
                  end
               end
            end
            dual_port_i2c_pkg::PS_ACK: begin
               if (sclFall) begin
                  // release after the acknowledge clock
                  n.sdaPull = 1'b0; // [R12]
                  n.bitCnt  = `DPI_RST_CNT;
                  if (q.readDir) begin
                     n.state = dual_port_i2c_pkg::PS_LOAD;
                  end else begin
                     n.state = dual_port_i2c_pkg::PS_RX;
                  end
               end
            end
            dual_port_i2c_pkg::PS_RX: begin
               if (sclRise) begin
                  n.shift  = {q.shift[6:0], sdaS}; // [R9]
                  n.bitCnt = q.bitCnt + 4'h1;
               end else if (sclFall && q.bitCnt == `DPI_BYTE_BITS) begin
                  // first byte after the address is the register number
                  n.rxData  = q.shift;
                  n.rxIsReg = q.firstByte; // [R22]
                  if (q.firstByte) begin
                     n.regNum = q.shift; // [R22]
                  end
                  n.firstByte = 1'b0;
                  n.rxValid   = 1'b1;
                  n.state     = dual_port_i2c_pkg::PS_RXHOLD; // [R16]
               end
            end
            dual_port_i2c_pkg::PS_RXHOLD: begin
               // clock held low until the core takes the byte
               if (!q.rxValid || rxReady) begin
                  n.sdaPull = 1'b1; // [R13]
                  n.state   = dual_port_i2c_pkg::PS_ACK; // [R11]
               end
            end
            dual_port_i2c_pkg::PS_LOAD: begin
               // count byte first, then that many data bytes
               if (!needCore) begin
                  n.shift   = `DPI_FILL_BYTE;
                  n.sdaPull = 1'b0;
                  n.bitCnt  = `DPI_RST_CNT;
                  n.state   = dual_port_i2c_pkg::PS_TX;
               end else if (txValid) begin
                  n.shift   = txData;
                  n.sdaPull = ~txData[7];
                  n.bitCnt  = `DPI_RST_CNT;
                  n.state   = dual_port_i2c_pkg::PS_TX; // [R19]
                  if (q.countPhase) begin
                     n.remain     = txData; // [R24]
                     n.countPhase = 1'b0;
                  end else begin
                     n.remain = q.remain - 8'h01; // [R24]
                  end
               end
            end
            dual_port_i2c_pkg::PS_TX: begin
               if (sclRise) begin
                  n.bitCnt = q.bitCnt + 4'h1;
               end else if (sclFall) begin
                  if (q.bitCnt == `DPI_BYTE_BITS) begin
                     n.sdaPull = 1'b0; // [R12]
                     n.state   = dual_port_i2c_pkg::PS_MACK;
                  end else begin
                     // next bit changes only while the clock is low
                     n.shift   = {q.shift[6:0], 1'b0}; // [R9]
                     n.sdaPull = ~q.shift[6];
                  end
               end
            end
            dual_port_i2c_pkg::PS_MACK: begin
               if (sclRise) begin
                  n.masterAck = ~sdaS; // [R11]
               end else if (sclFall) begin
                  if (q.masterAck) begin
                     n.state = dual_port_i2c_pkg::PS_LOAD; // [R16]
                  end else begin
                     n.sdaPull = 1'b0; // [R15]
                     n.state   = dual_port_i2c_pkg::PS_DONE;
                  end
               end
            end
            dual_port_i2c_pkg::PS_DONE: begin
               n.sdaPull = 1'b0; // [R15]
            end
            default: begin
               n.state   = dual_port_i2c_pkg::PS_IDLE;
               n.sdaPull = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q            <= '0;
         q.state      <= dual_port_i2c_pkg::PS_IDLE; // [R2]
         q.sclSync    <= 2'h3;
         q.sdaSync    <= 2'h3;
         q.sclPrev    <= 1'b1;
         q.sdaPrev    <= 1'b1;
         q.bitCnt     <= `DPI_RST_CNT;
         q.shift      <= `DPI_RST_BYTE;
         q.rxData     <= `DPI_RST_BYTE;
         q.regNum     <= `DPI_RST_BYTE;
         q.remain     <= `DPI_RST_BYTE;
         q.ownAddr    <= `DPI_RST_ADDR;
         q.irqN       <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // open-drain pins: drive low only, enable high while pulling
   assign sdaOut  = 1'b0;
   assign sdaOe   = q.sdaPull; // [R8] [R12]
   assign sclOut  = 1'b0;
   assign sclOe   = (q.state == dual_port_i2c_pkg::PS_RXHOLD) |
                    ((q.state == dual_port_i2c_pkg::PS_LOAD) & needCore); // [R16] [R19]
   assign irqN    = q.irqN; // [R25]
   assign rxValid = q.rxValid;
   assign rxData  = q.rxData;
   assign rxIsReg = q.rxIsReg;
   assign regNum  = q.regNum;
   assign txReq   = (q.state == dual_port_i2c_pkg::PS_LOAD) & needCore;
   assign txCount = q.countPhase;
   assign busy    = (q.state != dual_port_i2c_pkg::PS_IDLE);

endmodule

// Behaviour
// [R1] two serial ports, same behaviour, each own data, clock and interrupt lines
// [R2] each port leaves reset as a bus target
// [R3] each port has its own event mask for its interrupt line
// [R4] ports work at standard and fast bus rates
// [R5] the controller begins a transfer only while the bus is idle
// [R6] start is data falling while clock high; it begins a transaction
// [R7] controller sends address msb first, direction bit last
// [R8] on own address the device pulls data low through the ninth clock
// [R9] one bit per clock pulse; data stable while clock high
// [R10] stop is data rising while clock high; device returns to idle
// [R11] any number of bytes; each byte followed by one acknowledge bit
// [R12] transmitter releases data after each byte for the acknowledge
// [R13] as receiver the device acknowledges every byte
// [R14] reading controller acknowledges all but the last byte
// [R15] after a missing acknowledge the device releases data for stop
// [R16] device may hold clock low after a byte until ready
// [R17] controller waits while the clock is stretched
// [R18] controller keeps a minimum high time after a stretch, 4 us standard
// [R19] any clock pulse may be stretched, usually near the acknowledge
// [R20] boot fixes the address before the port responds
// [R21] address is fixed upper bits, strap field in bits 3..1, direction bit 0
// [R22] first written byte is the register number, later bytes its data
// [R23] strap field is zero for grounded strap, all ones for open strap
// [R24] a read returns a byte count N, then N data bytes
// [R25] interrupt line low while any unmasked event pending, else high
module dual_port_i2c_target (
   // clock and reset
   input  wire logic                             clk,
   input  wire logic                             rstn,
   // port a pins
   input  wire logic                             port_a_serial_clock_in,
   output logic                                  port_a_serial_clock_out,
   output logic                                  port_a_serial_clock_oe,
   input  wire logic                             port_a_serial_data_in,
   output logic                                  port_a_serial_data_out,
   output logic                                  port_a_serial_data_oe,
   output logic                                  port_a_interrupt_n,
   // port b pins
   input  wire logic                             port_b_serial_clock_in,
   output logic                                  port_b_serial_clock_out,
   output logic                                  port_b_serial_clock_oe,
   input  wire logic                             port_b_serial_data_in,
   output logic                                  port_b_serial_data_out,
   output logic                                  port_b_serial_data_oe,
   output logic                                  port_b_interrupt_n,
   // boot and strap
   input  wire logic                             bootDone,
   input  wire logic [2:0]                       strapCode,
   // events, index 0 port a, index 1 port b
   input  wire logic [1:0][`DPI_EVENT_W-1:0]     eventPending,
   input  wire logic [1:0][`DPI_EVENT_W-1:0]     eventMask,
   // received bytes
   output logic [1:0]                            rxValid,
   input  wire logic [1:0]                       rxReady,
   output logic [1:0][7:0]                       rxData,
   output logic [1:0]                            rxIsReg,
   output logic [1:0][7:0]                       regNum,
   // bytes to send
   output logic [1:0]                            txReq,
   output logic [1:0]                            txCount,
   input  wire logic [1:0]                       txValid,
   input  wire logic [1:0][7:0]                  txData,
   // status
   output logic [1:0]                            busy
);

   // identical ports with the same core access
   i2c_target_port portA ( // [R1] [R4]
      .clk          (clk),
      .rstn         (rstn),
      .sclIn        (port_a_serial_clock_in),
      .sclOut       (port_a_serial_clock_out),
      .sclOe        (port_a_serial_clock_oe),
      .sdaIn        (port_a_serial_data_in),
      .sdaOut       (port_a_serial_data_out),
      .sdaOe        (port_a_serial_data_oe),
      .irqN         (port_a_interrupt_n),
      .bootDone     (bootDone),
      .strapCode    (strapCode),
      .eventPending (eventPending[0]),
      .eventMask    (eventMask[0]),
      .rxValid      (rxValid[0]),
      .rxReady      (rxReady[0]),
      .rxData       (rxData[0]),
      .rxIsReg      (rxIsReg[0]),
      .regNum       (regNum[0]),
      .txReq        (txReq[0]),
      .txCount      (txCount[0]),
      .txValid      (txValid[0]),
      .txData       (txData[0]),
      .busy         (busy[0])
   );

   i2c_target_port portB ( // [R1] [R4]
      .clk          (clk),
      .rstn         (rstn),
      .sclIn        (port_b_serial_clock_in),
      .sclOut       (port_b_serial_clock_out),
      .sclOe        (port_b_serial_clock_oe),
      .sdaIn        (port_b_serial_data_in),
      .sdaOut       (port_b_serial_data_out),
      .sdaOe        (port_b_serial_data_oe),
      .irqN         (port_b_interrupt_n),
      .bootDone     (bootDone),
      .strapCode    (strapCode),
      .eventPending (eventPending[1]),
      .eventMask    (eventMask[1]),
      .rxValid      (rxValid[1]),
      .rxReady      (rxReady[1]),
      .rxData       (rxData[1]),
      .rxIsReg      (rxIsReg[1]),
      .regNum       (regNum[1]),
      .txReq        (txReq[1]),
      .txCount      (txCount[1]),
      .txValid      (txValid[1]),
      .txData       (txData[1]),
      .busy         (busy[1])
   );

endmodule

// ==== sim/dual_port_i2c_target_checker.sv ====
module dual_port_i2c_target_checker (
   // clock and reset
   input logic            clk,
   input logic            rstn,
   // pins
   input logic            port_a_serial_clock_oe,
   input logic            port_a_serial_data_oe,
   input logic            port_a_interrupt_n,
   input logic            port_b_serial_clock_oe,
   input logic            port_b_serial_data_oe,
   input logic            port_b_interrupt_n,
   // core side
   input logic [1:0][7:0] eventPending,
   input logic [1:0][7:0] eventMask,
   input logic [1:0]      rxValid,
   input logic [1:0]      rxReady,
   input logic [1:0][7:0] rxData,
   input logic [1:0]      txReq,
   input logic [1:0]      txCount,
   input logic [1:0]      txValid,
   input logic [1:0][7:0] txData,
   input logic [1:0]      busy
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   AST_IRQ_A: assert property (
      port_a_interrupt_n == !(|($past(eventPending[0]) & $past(eventMask[0]))))
      else $error("port a interrupt line wrong");
   AST_IRQ_B: assert property (
      port_b_interrupt_n == !(|($past(eventPending[1]) & $past(eventMask[1]))))
      else $error("port b interrupt line wrong");
   AST_RX_STRETCH: assert property (
      rxValid[0] && !rxReady[0] |-> port_a_serial_clock_oe)
      else $error("clock not held while byte waits");
   AST_TX_STRETCH: assert property (
      txReq[1] |-> port_b_serial_clock_oe)
      else $error("clock not held while send byte wanted");
   AST_TX_TAKE: assert property (
      txReq[1] && txValid[1] |=> !txReq[1] && !port_b_serial_clock_oe
         && port_b_serial_data_oe == !$past(txData[1][7]))
      else $error("send byte not taken");
   AST_RX_HOLD: assert property (
      rxValid[0] && !rxReady[0] |=> rxValid[0] && $stable(rxData[0]))
      else $error("received byte dropped early");
   AST_RX_DROP: assert property (
      rxValid[0] && rxReady[0] |=> !rxValid[0])
      else $error("received byte not cleared");
   AST_IDLE_QUIET: assert property (
      !busy[0] |-> !port_a_serial_data_oe)
      else $error("data pulled while idle");
   AST_ACK_HOLD: assert property (
      $rose(port_a_serial_data_oe) |-> port_a_serial_data_oe[*3])
      else $error("data pull too short");

   cover property (rxValid[0] && rxReady[0]);
   cover property (txReq[1] && txValid[1] && txCount[1]);
   cover property ($fell(port_b_interrupt_n));
endmodule

// ==== sim/i2c_ctrl_model.sv ====
module i2c_ctrl_model (
   // clock
   input  wire logic clk,
   // wire levels
   input  wire logic sclLine,
   input  wire logic sdaLine,
   // open-drain pulls
   output logic      sclLow,
   output logic      sdaLow
);
   timeunit 1ns;
   timeprecision 1ns;

   int q = 13;

   initial begin
      sclLow = 1'b0;
      sdaLow = 1'b0;
   end

   task automatic waitq(input int n);
      repeat (n * q) @(negedge clk);
   endtask

   // release clock, sit out a stretch, then hold high
   task automatic clkHigh();
      int t;
      t = 0;
      sclLow = 1'b0;
      while (sclLine !== 1'b1 && t < 30000) begin
         @(negedge clk);
         t++;
      end
      waitq(2);
   endtask

   task automatic bitx(input logic v, output logic r);
      sdaLow = !v;
      waitq(1);
      clkHigh();
      r = sdaLine;
      sclLow = 1'b1;
      waitq(1);
   endtask

   // k: 0 start, 1 stop, 2 byte plus acknowledge bit
   task automatic op(input int k, input logic [7:0] tx, input logic ab,
                     output logic [7:0] rx, output logic ack);
      rx = 8'h00;
      ack = 1'b1;
      if (k == 2) begin
         for (int i = 7; i >= 0; i--) begin
            bitx(tx[i], rx[i]);
         end
         bitx(ab, ack);
      end else begin
         sdaLow = (k != 0);
         waitq(1);
         clkHigh();
         sdaLow = !sdaLow;
         waitq(1);
         sclLow = (k == 0);
         waitq(1);
      end
   endtask
endmodule

// ==== sim/tb_dual_port_i2c_target.sv ====
`include "dual_port_i2c_defs.svh"

module tb_dual_port_i2c_target;
   timeunit 1ns;
   timeprecision 1ns;

   logic            clk, rstn, bootDone, ack;
   logic [2:0]      strapCode, strap;
   logic [1:0][7:0] eventPending, eventMask, rxData, regNum, txData;
   logic [1:0]      rxValid, rxReady, rxIsReg, txReq, txCount, txValid, busy;
   logic [1:0]      scl, sda, sclOe, sdaOe, irqN, mScl, mSda;
   logic [7:0]      rxb, txN[2], txBase[2], txIdx[2];
   logic [8:0]      expQ[2][$];
   int              stall[2];
   int              nErrors = 0;
   int              nChecks = 0;

   // open-drain wires with pull-ups
   assign scl = ~(mScl | sclOe);
   assign sda = ~(mSda | sdaOe);

   dual_port_i2c_target u_dut (
      .clk, .rstn, .bootDone, .strapCode, .eventPending, .eventMask,
      .rxValid, .rxReady, .rxData, .rxIsReg, .regNum,
      .txReq, .txCount, .txValid, .txData, .busy,
      .port_a_serial_clock_in(scl[0]), .port_a_serial_clock_out(),
      .port_a_serial_clock_oe(sclOe[0]), .port_a_serial_data_in(sda[0]),
      .port_a_serial_data_out(), .port_a_serial_data_oe(sdaOe[0]),
      .port_a_interrupt_n(irqN[0]), .port_b_serial_clock_in(scl[1]),
      .port_b_serial_clock_out(), .port_b_serial_clock_oe(sclOe[1]),
      .port_b_serial_data_in(sda[1]), .port_b_serial_data_out(),
      .port_b_serial_data_oe(sdaOe[1]), .port_b_interrupt_n(irqN[1])
   );

   i2c_ctrl_model u_ma (.clk, .sclLine(scl[0]), .sdaLine(sda[0]),
                        .sclLow(mScl[0]), .sdaLow(mSda[0]));
   i2c_ctrl_model u_mb (.clk, .sclLine(scl[1]), .sdaLine(sda[1]),
                        .sclLow(mScl[1]), .sdaLow(mSda[1]));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic completeRun();
      $display("checks %0d errors %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      nChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input int p, input int k, input logic [7:0] tx, input logic ab);
      if (p == 0) begin
         u_ma.op(k, tx, ab, rxb, ack);
      end else begin
         u_mb.op(k, tx, ab, rxb, ack);
      end
   endtask

   // address alone, then stop
   task automatic probe(input int p, input logic [7:0] adr, input logic expAck);
      bus(p, 0, 8'h00, 1'b1);
      bus(p, 2, adr, 1'b1);
      chk("address ack", 9'(expAck), 9'(ack));
      bus(p, 1, 8'h00, 1'b1);
   endtask

   task automatic boot(input logic [2:0] s);
      rstn = 1'b0;
      bootDone = 1'b0;
      strap = s;
      strapCode = s;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk("outputs after reset", 9'h00c, 9'({sclOe, sdaOe, irqN, busy}));
      probe(0, {`DPI_ADDR_UPPER, s, 1'b0}, 1'b1);
      bootDone = 1'b1;
      repeat (2) @(negedge clk);
   endtask

   task automatic wr(input int p, input int n);
      logic [7:0] v;
      bus(p, 0, 8'h00, 1'b1);
      bus(p, 2, {`DPI_ADDR_UPPER, strap, 1'b0}, 1'b1);
      chk("write address ack", 9'h000, 9'(ack));
      for (int i = 0; i <= n; i++) begin
         v = 8'($urandom);
         expQ[p].push_back({i == 0, v});
         bus(p, 2, v, 1'b1);
         chk("write byte ack", 9'h000, 9'(ack));
      end
      bus(p, 1, 8'h00, 1'b1);
      chk("busy after stop", 9'h000, 9'(busy[p]));
   endtask

   task automatic rd(input int p, input int n, input int cnt);
      logic [7:0] e;
      txN[p] = 8'(n);
      txBase[p] = 8'($urandom);
      e = 8'($urandom);
      expQ[p].push_back({1'b1, e});
      bus(p, 0, 8'h00, 1'b1);
      bus(p, 2, {`DPI_ADDR_UPPER, strap, 1'b0}, 1'b1);
      bus(p, 2, e, 1'b1);
      chk("register number", 9'(e), 9'(regNum[p]));
      bus(p, 0, 8'h00, 1'b1);
      bus(p, 2, {`DPI_ADDR_UPPER, strap, 1'b1}, 1'b1);
      chk("read address ack", 9'h000, 9'(ack));
      for (int i = 0; i < cnt; i++) begin
         e = (i == 0) ? 8'(n) : (i <= n) ? 8'(txBase[p] + i - 1) : `DPI_FILL_BYTE;
         bus(p, 2, 8'hff, i == cnt - 1);
         chk("read byte", 9'(e), 9'(rxb));
      end
      chk("data released after nack", 9'h000, 9'(sdaOe[p]));
      bus(p, 1, 8'h00, 1'b1);
   endtask

   // core side: check and accept received bytes, offer bytes to send
   always @(negedge clk) begin
      logic [8:0] e;
      for (int p = 0; p < 2; p++) begin
         if (rxValid[p] === 1'b1 && rxReady[p] !== 1'b1 && stall[p] > 0) begin
            stall[p]--;
         end else if (rxValid[p] === 1'b1 && rxReady[p] !== 1'b1) begin
            e = 9'bx;
            if (expQ[p].size() > 0) e = expQ[p].pop_front();
            chk("received byte", e, {rxIsReg[p], rxData[p]});
            rxReady[p] = 1'b1;
            stall[p] = $urandom_range(12);
         end else begin
            rxReady[p] = 1'b0;
         end
         if (txReq[p] === 1'b1 && txValid[p] !== 1'b1) begin
            txData[p] = (txCount[p] === 1'b1) ? txN[p] : 8'(txBase[p] + txIdx[p]);
            txIdx[p] = (txCount[p] === 1'b1) ? 8'h00 : 8'(txIdx[p] + 1);
            txValid[p] = 1'b1;
         end else if (txReq[p] !== 1'b1) begin
            txValid[p] = 1'b0;
         end
      end
   end

   initial begin
      repeat (100000) @(posedge clk);
      nErrors++;
      completeRun();
   end

   initial begin
      rstn = 1'b0;
      bootDone = 1'b0;
      strapCode = 3'h0;
      eventPending = '0;
      eventMask = '0;
      rxReady = '0;
      txValid = '0;
      txData = '0;
      void'($urandom(26));
      for (int i = 0; i < 3; i++) begin
         boot((i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom));
         wr(0, 3);
         probe(0, {`DPI_ADDR_UPPER, strap ^ 3'h1, 1'b0}, 1'b1);
         probe(1, {`DPI_ADDR_UPPER, strap, 1'b0}, 1'b0);
      end
      rd(1, 2, 4);
      rd(1, 0, 2);
      u_ma.q = 50;
      u_mb.q = 50;
      wr(1, 2);
      rd(0, 1, 3);
      for (int i = 0; i < 8; i++) begin
         eventPending = {8'($urandom), 8'($urandom)};
         eventMask = {8'(1 << $urandom_range(7)), 8'(1 << $urandom_range(7))};
         repeat (2) @(negedge clk);
         for (int p = 0; p < 2; p++) begin
            chk("interrupt", 9'(!(|(eventPending[p] & eventMask[p]))), 9'(irqN[p]));
         end
      end
      completeRun();
   end
endmodule

bind dual_port_i2c_target dual_port_i2c_target_checker u_chk (
   .clk, .rstn, .port_a_serial_clock_oe, .port_a_serial_data_oe, .port_a_interrupt_n,
   .port_b_serial_clock_oe, .port_b_serial_data_oe, .port_b_interrupt_n, .eventPending,
   .eventMask, .rxValid, .rxReady, .rxData, .txReq, .txCount, .txValid, .txData, .busy
);
